//--- txf_defs.svh
/*
 * offsets, field positions, reset values and timing figures of the
 * transmit frontend configuration bank.
 * assumes: included by bare name from every file that needs a figure.
 */
`ifndef TXF_DEFS_SVH
`define TXF_DEFS_SVH

////////////////////////////////////////////////////////////////////////////
// register addresses on the control port
`define TXF_ADDR_W 14
`define TXF_OFF_IQIFC0 14'h000a
`define TXF_OFF_FILT_RAMP 14'h0112
`define TXF_OFF_DFE 14'h0113
`define TXF_OFF_PA_CTRL 14'h0114
`define TXF_OFF_AUX 14'h0101

////////////////////////////////////////////////////////////////////////////
// field positions: msb, lsb
`define TXF_RAMP_MSB 7
`define TXF_RAMP_LSB 6
`define TXF_LPF_MSB 3
`define TXF_LPF_LSB 0
`define TXF_TX_REL_CUTOFF_SEL_MSB 7
`define TXF_TX_REL_CUTOFF_SEL_LSB 5
`define TXF_DM_BIT 4
`define TXF_SR_MSB 3
`define TXF_SR_LSB 0
`define TXF_BIAS_MSB 6
`define TXF_BIAS_LSB 5
`define TXF_PWR_MSB 4
`define TXF_PWR_LSB 0
`define TXF_PA_SUPPLY_VOLTAGE_SEL_MSB 1
`define TXF_PA_SUPPLY_VOLTAGE_SEL_LSB 0
`define TXF_IQ_RO_BIT 6
`define TXF_EEC_BIT 0

////////////////////////////////////////////////////////////////////////////
// reset values of whole registers and of the read/write masks
`define TXF_RST_IQIFC0 8'h14
`define TXF_RST_FILT_RAMP 8'h08
`define TXF_RST_DFE 8'h01
`define TXF_RST_PA_CTRL 8'h7f
`define TXF_RST_AUX 8'h02
`define TXF_MASK_IQIFC0_RW 8'hbf
`define TXF_MASK_FILT_RAMP 8'hcf
`define TXF_MASK_DFE 8'hff
`define TXF_MASK_PA_CTRL 8'h7f
`define TXF_MASK_AUX 8'h03

////////////////////////////////////////////////////////////////////////////
// sample-rate codes that the frontend knows; anything else falls back
`define TXF_SR_DEFAULT 4'h1
`define TXF_SR_VALID_SET 16'h057e

////////////////////////////////////////////////////////////////////////////
// pa ramp times in microseconds and the clock rate in MHz
`define TXF_CLK_MHZ 100
`define TXF_RAMP_US_0 4
`define TXF_RAMP_US_1 8
`define TXF_RAMP_US_2 16
`define TXF_RAMP_US_3 32
`define TXF_RAMP_CYC(us) ((us) * `TXF_CLK_MHZ)

`endif

//--- txf_pkg.sv
/*
 * types shared by the transmit frontend configuration bank.
 * assumes: nothing beyond the defs header.
 */
package txf_pkg;

  // transmit control state
  typedef enum logic [0:0] {
    TXF_ST_IDLE,
    TXF_ST_TX
  } txf_tx_state_t;

  // eight-bit register word
  typedef logic [7:0] txf_byte_t;

endpackage : txf_pkg

//--- txf_ctrl_if.sv
/*
 * carrier between the register bank and its transmit start/stop control.
 * assumes: both ends on ref_clk_in.
 */
interface txf_ctrl_if;
  logic embedded_tx_ctrl_en; // embedded control selected
  logic cmd_tx_start;        // port command: start transmit
  logic cmd_tx_prepare;      // port command: back to prepare state
  logic iq_ctrl_bit;         // lsb of in-phase sample word
  logic iq_valid;            // sample word strobe
  logic tx_prepare_state;    // transceiver sits in prepare state
  logic tx_active;           // transmit running

  modport regs (output embedded_tx_ctrl_en, output cmd_tx_start, output cmd_tx_prepare,
                output iq_ctrl_bit, output iq_valid, output tx_prepare_state,
                input tx_active);
  modport ctrl (input embedded_tx_ctrl_en, input cmd_tx_start, input cmd_tx_prepare,
                input iq_ctrl_bit, input iq_valid, input tx_prepare_state,
                output tx_active);
endinterface : txf_ctrl_if

//--- txf_tx_ctrl.sv
/*
 * transmit start/stop control: port commands or embedded i/q bit.
 * assumes: all inputs on ref_clk_in, synchronous active-high reset.
 */
`include "txf_defs.svh"

module txf_tx_ctrl (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  txf_ctrl_if.ctrl ctl
);

  txf_pkg::txf_tx_state_t state_q; // idle or transmitting

  ////////////////////////////////////////////////////////////////////////////
  // start/stop sequencing
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= txf_pkg::TXF_ST_IDLE;
    end else begin
      case (state_q)
        txf_pkg::TXF_ST_IDLE: begin
          // start only from the prepare state
          if (ctl.tx_prepare_state) begin
            if (ctl.embedded_tx_ctrl_en) begin
              // port start command ignored here
              if (ctl.iq_valid && ctl.iq_ctrl_bit) begin
                state_q <= txf_pkg::TXF_ST_TX;
              end
            end else if (ctl.cmd_tx_start) begin
              state_q <= txf_pkg::TXF_ST_TX;
            end
          end
        end
        txf_pkg::TXF_ST_TX: begin
          if (ctl.embedded_tx_ctrl_en) begin
            // stop on a sample with the control bit clear
            if (ctl.iq_valid && !ctl.iq_ctrl_bit) begin
              state_q <= txf_pkg::TXF_ST_IDLE;
            end
          end else if (ctl.cmd_tx_prepare) begin
            state_q <= txf_pkg::TXF_ST_IDLE;
          end
        end
        default: begin
          state_q <= txf_pkg::TXF_ST_IDLE;
        end
      endcase
    end
  end

  // registered state drives the flag directly
  assign ctl.tx_active = (state_q == txf_pkg::TXF_ST_TX);

endmodule : txf_tx_ctrl

//--- txf_config_regs.sv
/*
 * transmit frontend configuration bank: filter, ramp, digital frontend,
 * pa control, pa supply and i/q interface configuration, plus the
 * transmit start/stop control that the embedded-control bit selects.
 * assumes: host reaches the bank through a word port already decoded
 * from the serial control interface on ref_clk_in; i/q sample strobe
 * and prepare-state level also come from ref_clk_in logic.
 */
`include "txf_defs.svh"

module txf_config_regs (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // register port
  input wire logic [`TXF_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // transmit commands and stream
  input wire logic cmd_tx_start_in,
  input wire logic cmd_tx_prepare_in,
  input wire logic tx_prepare_state_in,
  input wire logic iq_ctrl_bit_in,
  input wire logic iq_valid_in,
  input wire logic iq_status_flag_in,
  output logic tx_active_out,
  // decoded configuration
  output logic [1:0] pa_ramp_time_sel_out,
  output logic [15:0] pa_ramp_cycles_out,
  output logic [3:0] tx_lpf_cutoff_sel_out,
  output logic [2:0] tx_rel_cutoff_sel_out,
  output logic direct_mod_enable_out,
  output logic [3:0] tx_sample_rate_sel_out,
  output logic [1:0] pa_bias_current_sel_out,
  output logic [4:0] tx_power_level_out,
  output logic [1:0] pa_supply_voltage_sel_out,
  output logic [7:0] iq_interface_config0_out,
  output logic embedded_tx_ctrl_en_out
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  txf_pkg::txf_byte_t iq_interface_config0_q; // rw bits only, bit 6 held zero
  txf_pkg::txf_byte_t tx_filter_ramp_ctrl_q;  // ramp and lpf fields
  txf_pkg::txf_byte_t tx_digital_frontend_cfg_q; // tx_rel_cutoff_sel, dm, sample rate
  txf_pkg::txf_byte_t pa_control_q;           // bias and power
  txf_pkg::txf_byte_t aux_settings_q;         // pa supply
  txf_pkg::txf_byte_t rdata_q;                // read data hold
  logic rvalid_q;                              // read answer strobe
  txf_pkg::txf_byte_t rdata_d;                // selected read word
  logic [3:0] sr_eff;                          // sample rate after fallback
  logic [15:0] sr_valid_set;                   // one bit per defined sample-rate code
  logic [15:0] ramp_cyc;                       // ramp length in clocks

  // address hits, one per register
  logic hit_iq;
  logic hit_filt;
  logic hit_dfe;
  logic hit_pa;
  logic hit_aux;

  assign hit_iq = (reg_addr_in == `TXF_OFF_IQIFC0);
  assign hit_filt = (reg_addr_in == `TXF_OFF_FILT_RAMP);
  assign hit_dfe = (reg_addr_in == `TXF_OFF_DFE);
  assign hit_pa = (reg_addr_in == `TXF_OFF_PA_CTRL);
  assign hit_aux = (reg_addr_in == `TXF_OFF_AUX);

  ////////////////////////////////////////////////////////////////////////////
  // i/q interface configuration register
  // bit 6 is never stored; it reads the live status flag instead
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      iq_interface_config0_q <= `TXF_RST_IQIFC0;
    end else if (reg_wr_in && hit_iq) begin
      iq_interface_config0_q <= reg_wdata_in & `TXF_MASK_IQIFC0_RW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter cutoff and pa ramp register
  // bits 5:4 carry no field, so the mask keeps them at zero
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_filter_ramp_ctrl_q <= `TXF_RST_FILT_RAMP;
    end else if (reg_wr_in && hit_filt) begin
      tx_filter_ramp_ctrl_q <= reg_wdata_in & `TXF_MASK_FILT_RAMP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital frontend register
  // raw sample-rate code is kept so software reads back what it wrote
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_digital_frontend_cfg_q <= `TXF_RST_DFE;
    end else if (reg_wr_in && hit_dfe) begin
      tx_digital_frontend_cfg_q <= reg_wdata_in & `TXF_MASK_DFE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pa control register
  // power code resets to full power, matching the unreduced bias default
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pa_control_q <= `TXF_RST_PA_CTRL;
    end else if (reg_wr_in && hit_pa) begin
      pa_control_q <= reg_wdata_in & `TXF_MASK_PA_CTRL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auxiliary settings register
  // code 3 of the supply field is stored as written; no level defined
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      aux_settings_q <= `TXF_RST_AUX;
    end else if (reg_wr_in && hit_aux) begin
      aux_settings_q <= reg_wdata_in & `TXF_MASK_AUX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word select; unmapped addresses answer zero
  always_comb begin
    rdata_d = 8'h00;
    if (hit_iq) begin
      rdata_d = iq_interface_config0_q;
      rdata_d[`TXF_IQ_RO_BIT] = iq_status_flag_in;
    end else if (hit_filt) begin
      rdata_d = tx_filter_ramp_ctrl_q;
    end else if (hit_dfe) begin
      rdata_d = tx_digital_frontend_cfg_q;
    end else if (hit_pa) begin
      rdata_d = pa_control_q;
    end else if (hit_aux) begin
      rdata_d = aux_settings_q;
    end
  end

  // read answer one clock after the request
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // a literal cannot be bit-selected, so the code set lives in a vector
  assign sr_valid_set = `TXF_SR_VALID_SET;

  // sample-rate fallback: the frontend never sees an undefined code
  always_comb begin
    sr_eff = tx_digital_frontend_cfg_q[`TXF_SR_MSB:`TXF_SR_LSB];
    if (!sr_valid_set[sr_eff]) begin
      sr_eff = `TXF_SR_DEFAULT;
    end
  end

  // ramp length in clocks for the selected ramp code
  always_comb begin
    ramp_cyc = 16'(`TXF_RAMP_CYC(`TXF_RAMP_US_0));
    case (tx_filter_ramp_ctrl_q[`TXF_RAMP_MSB:`TXF_RAMP_LSB])
      2'h1: ramp_cyc = 16'(`TXF_RAMP_CYC(`TXF_RAMP_US_1));
      2'h2: ramp_cyc = 16'(`TXF_RAMP_CYC(`TXF_RAMP_US_2));
      2'h3: ramp_cyc = 16'(`TXF_RAMP_CYC(`TXF_RAMP_US_3));
      default: ramp_cyc = 16'(`TXF_RAMP_CYC(`TXF_RAMP_US_0));
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs straight from the stored fields, except sample rate (after fallback) and ramp length in clocks
  assign pa_ramp_time_sel_out = tx_filter_ramp_ctrl_q[`TXF_RAMP_MSB:`TXF_RAMP_LSB];
  assign pa_ramp_cycles_out = ramp_cyc;
  assign tx_lpf_cutoff_sel_out = tx_filter_ramp_ctrl_q[`TXF_LPF_MSB:`TXF_LPF_LSB];
  assign tx_rel_cutoff_sel_out = tx_digital_frontend_cfg_q[`TXF_TX_REL_CUTOFF_SEL_MSB:`TXF_TX_REL_CUTOFF_SEL_LSB];
  assign direct_mod_enable_out = tx_digital_frontend_cfg_q[`TXF_DM_BIT];
  assign tx_sample_rate_sel_out = sr_eff;
  assign pa_bias_current_sel_out = pa_control_q[`TXF_BIAS_MSB:`TXF_BIAS_LSB];
  assign tx_power_level_out = pa_control_q[`TXF_PWR_MSB:`TXF_PWR_LSB];
  assign pa_supply_voltage_sel_out = aux_settings_q[`TXF_PA_SUPPLY_VOLTAGE_SEL_MSB:`TXF_PA_SUPPLY_VOLTAGE_SEL_LSB];
  assign iq_interface_config0_out = iq_interface_config0_q;
  assign embedded_tx_ctrl_en_out = iq_interface_config0_q[`TXF_EEC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // transmit start/stop control
  // direct modulation legality (modulation, chip rate) is left to software
  txf_ctrl_if ctl_if ();

  assign ctl_if.embedded_tx_ctrl_en = iq_interface_config0_q[`TXF_EEC_BIT];
  assign ctl_if.cmd_tx_start = cmd_tx_start_in;
  assign ctl_if.cmd_tx_prepare = cmd_tx_prepare_in;
  assign ctl_if.iq_ctrl_bit = iq_ctrl_bit_in;
  assign ctl_if.iq_valid = iq_valid_in;
  assign ctl_if.tx_prepare_state = tx_prepare_state_in;
  assign tx_active_out = ctl_if.tx_active;

  txf_tx_ctrl u_tx_ctrl (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .ctl(ctl_if.ctrl)
  );

endmodule : txf_config_regs

//--- txf_regs_properties.sv
/*
 * concurrent checks on the ports of the transmit frontend config bank.
 * assumes: bound to txf_config_regs; one clock, sync active-high reset.
 */
`include "txf_defs.svh"

module txf_regs_properties (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [`TXF_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic tx_prepare_state_in,
  input wire logic iq_ctrl_bit_in,
  input wire logic iq_valid_in,
  input wire logic iq_status_flag_in,
  input wire logic tx_active_out,
  input wire logic [1:0] pa_ramp_time_sel_out,
  input wire logic [15:0] pa_ramp_cycles_out,
  input wire logic [3:0] tx_lpf_cutoff_sel_out,
  input wire logic [2:0] tx_rel_cutoff_sel_out,
  input wire logic direct_mod_enable_out,
  input wire logic [3:0] tx_sample_rate_sel_out,
  input wire logic [1:0] pa_bias_current_sel_out,
  input wire logic [4:0] tx_power_level_out,
  input wire logic [1:0] pa_supply_voltage_sel_out,
  input wire logic [7:0] iq_interface_config0_out,
  input wire logic embedded_tx_ctrl_en_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // set of sample-rate codes the frontend accepts as they are
  logic [15:0] sr_ok;
  assign sr_ok = `TXF_SR_VALID_SET;
  // write strobe to one offset
  sequence s_wr(a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  // embedded start: idle, prepared, stream bit high
  sequence s_start;
    embedded_tx_ctrl_en_out && !tx_active_out && tx_prepare_state_in && iq_valid_in
      && iq_ctrl_bit_in;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_RAMP_CYC: assert property (pa_ramp_cycles_out == (16'd400 << pa_ramp_time_sel_out))
    else $error("ramp cycle count does not match code");
  AST_FILT_WR: assert property (s_wr(`TXF_OFF_FILT_RAMP) |=>
    {pa_ramp_time_sel_out, tx_lpf_cutoff_sel_out} == $past({reg_wdata_in[7:6], reg_wdata_in[3:0]}))
    else $error("filter/ramp fields not taken from write");
  AST_DFE_WR: assert property (s_wr(`TXF_OFF_DFE) |=>
    {tx_rel_cutoff_sel_out, direct_mod_enable_out} == $past(reg_wdata_in[7:4]))
    else $error("cutoff or direct modulation not taken from write");
  AST_SR_MAP: assert property (s_wr(`TXF_OFF_DFE) |=> tx_sample_rate_sel_out ==
    ($past(sr_ok[reg_wdata_in[3:0]]) ? $past(reg_wdata_in[3:0]) : 4'h1))
    else $error("sample rate code not mapped");
  AST_PA_WR: assert property (s_wr(`TXF_OFF_PA_CTRL) |=>
    {pa_bias_current_sel_out, tx_power_level_out} == $past(reg_wdata_in[6:0]))
    else $error("pa bias or power not taken from write");
  AST_PA_SUPPLY_VOLTAGE_SEL_WR: assert property (s_wr(`TXF_OFF_AUX) |=>
    pa_supply_voltage_sel_out == $past(reg_wdata_in[1:0]))
    else $error("pa supply code not taken from write");
  AST_IQ_RO: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == `TXF_OFF_IQIFC0 |=>
    reg_rvalid_out && reg_rdata_out == {iq_interface_config0_out[7], $past(iq_status_flag_in),
    iq_interface_config0_out[5:0]})
    else $error("iq config read wrong");
  AST_RD_ZERO: assert property (reg_rd_in && reg_addr_in == `TXF_OFF_FILT_RAMP |=>
    reg_rvalid_out && reg_rdata_out[5:4] == 2'h0)
    else $error("unassigned bits not zero");
  AST_EEC_HOLD: assert property (embedded_tx_ctrl_en_out && !tx_active_out &&
    !(iq_valid_in && iq_ctrl_bit_in) |=> !tx_active_out)
    else $error("transmit started without stream bit");
  AST_STREAM_START: assert property (s_start |=> tx_active_out)
    else $error("stream bit did not start transmit");
endmodule : txf_regs_properties

//--- txf_host_model.sv
/*
 * host side: register strobes, port commands and the i/q control bit.
 * assumes: same clock as the bank; tasks called from the bench.
 */
`include "txf_defs.svh"

module txf_host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  output logic [`TXF_ADDR_W-1:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out,
  output logic cmd_tx_start_out,
  output logic cmd_tx_prepare_out,
  output logic iq_ctrl_bit_out,
  output logic iq_valid_out
);
  initial begin
    {reg_addr_out, reg_wr_out, reg_wdata_out, reg_rd_out, cmd_tx_start_out,
      cmd_tx_prepare_out, iq_ctrl_bit_out, iq_valid_out} = '0;
  end
  // idle bus shows inverted values so stale data never passes for fresh
  task automatic wr(input logic [`TXF_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
    #1;
  endtask : wr
  // answer comes exactly one cycle after the strobe
  task automatic rd(input logic [`TXF_ADDR_W-1:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    d = reg_rdata_in;
    v = reg_rvalid_in;
  endtask : rd
  // k: 0 start command, 1 prepare command, else stream word with bit b
  task automatic pulse(input int k, input logic b);
    @(posedge ref_clk_in);
    case (k)
      0: cmd_tx_start_out <= 1'b1;
      1: cmd_tx_prepare_out <= 1'b1;
      default: begin
        iq_ctrl_bit_out <= b;
        iq_valid_out <= 1'b1;
      end
    endcase
    @(posedge ref_clk_in);
    {cmd_tx_start_out, cmd_tx_prepare_out, iq_valid_out} <= 3'h0;
    iq_ctrl_bit_out <= ~b;
    #1;
  endtask : pulse
endmodule : txf_host_model

//--- txf_config_regs_tb.sv
/*
 * self-checking bench for the transmit frontend config bank.
 * assumes: host model drives the register port and transmit stream.
 */
`include "txf_defs.svh"

module txf_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, srst_in, reg_wr_in, reg_rd_in, reg_rvalid_out, cmd_tx_start_in;
  logic cmd_tx_prepare_in, tx_prepare_state_in, iq_ctrl_bit_in, iq_valid_in, iq_status_flag_in;
  logic tx_active_out, direct_mod_enable_out, embedded_tx_ctrl_en_out;
  logic [`TXF_ADDR_W-1:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, iq_interface_config0_out;
  logic [1:0] pa_ramp_time_sel_out, pa_bias_current_sel_out, pa_supply_voltage_sel_out;
  logic [15:0] pa_ramp_cycles_out;
  logic [3:0] tx_lpf_cutoff_sel_out, tx_sample_rate_sel_out;
  logic [2:0] tx_rel_cutoff_sel_out;
  logic [4:0] tx_power_level_out;
  int n_fail = 0;
  int comparisons = 0;
  // offsets, reset words and writable masks of the five registers
  logic [`TXF_ADDR_W-1:0] offs [5] = '{`TXF_OFF_IQIFC0, `TXF_OFF_FILT_RAMP, `TXF_OFF_DFE,
    `TXF_OFF_PA_CTRL, `TXF_OFF_AUX};
  logic [7:0] rstv [5] = '{8'h14, 8'h08, 8'h01, 8'h7f, 8'h02};
  logic [7:0] msk [5] = '{8'hbf, 8'hcf, 8'hff, 8'h7f, 8'h03};

  txf_config_regs dut (.ref_clk_in, .srst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .cmd_tx_start_in, .cmd_tx_prepare_in,
    .tx_prepare_state_in, .iq_ctrl_bit_in, .iq_valid_in, .iq_status_flag_in, .tx_active_out,
    .pa_ramp_time_sel_out, .pa_ramp_cycles_out, .tx_lpf_cutoff_sel_out, .tx_rel_cutoff_sel_out,
    .direct_mod_enable_out, .tx_sample_rate_sel_out, .pa_bias_current_sel_out,
    .tx_power_level_out, .pa_supply_voltage_sel_out, .iq_interface_config0_out,
    .embedded_tx_ctrl_en_out);
  txf_host_model host (.ref_clk_in, .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out),
    .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in),
    .reg_rd_out(reg_rd_in), .cmd_tx_start_out(cmd_tx_start_in),
    .cmd_tx_prepare_out(cmd_tx_prepare_in), .iq_ctrl_bit_out(iq_ctrl_bit_in),
    .iq_valid_out(iq_valid_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [`TXF_ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk("rvalid", 16'(v), 16'h1);
    chk("rdata", 16'(d), 16'(e));
  endtask : rchk
  task automatic txchk(input int k, input logic b, input logic e);
    host.pulse(k, b);
    chk("tx_active", 16'(tx_active_out), 16'(e));
  endtask : txchk
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // whole run is about 120 cycles; this limit of 20000 cycles is far beyond it
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  initial begin
    logic [3:0] c;
    srst_in = 1'b1;
    tx_prepare_state_in = 1'b0;
    iq_status_flag_in = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    // reset words, then an unmapped place
    for (int i = 0; i < 5; i++) rchk(offs[i], rstv[i]);
    rchk(14'h3fff, 8'h00);
    // unassigned bits drop, read-only bit shows the status flag
    @(posedge ref_clk_in);
    iq_status_flag_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      host.wr(offs[i], 8'hfe);
      rchk(offs[i], (8'hfe & msk[i]) | ((i == 0) ? 8'h40 : 8'h00));
    end
    chk("rel_cutoff", 16'(tx_rel_cutoff_sel_out), 16'h7);
    chk("direct_mod", 16'(direct_mod_enable_out), 16'h1);
    chk("sample_rate", 16'(tx_sample_rate_sel_out), 16'h1);
    // every sample-rate code, defined ones kept, others fall back
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      host.wr(`TXF_OFF_DFE, {4'h0, c});
      chk("sample_rate", 16'(tx_sample_rate_sel_out),
        16'((c inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'ha}) ? c : 4'h1));
    end
    // ramp codes with cut-off code b, spare bits written high
    for (int i = 0; i < 4; i++) begin
      host.wr(`TXF_OFF_FILT_RAMP, {i[1:0], 6'h3b});
      chk("ramp_cycles", pa_ramp_cycles_out, 16'(400 << i));
      chk("ramp_sel", 16'(pa_ramp_time_sel_out), 16'(i));
      chk("lpf_cutoff", 16'(tx_lpf_cutoff_sel_out), 16'hb);
      rchk(`TXF_OFF_FILT_RAMP, {i[1:0], 6'h0b});
      host.wr(`TXF_OFF_PA_CTRL, {1'b1, i[1:0], i[0] ? 5'h1f : 5'h00});
      chk("pa_bias", 16'(pa_bias_current_sel_out), 16'(i));
      chk("tx_power", 16'(tx_power_level_out), i[0] ? 16'h1f : 16'h0);
      host.wr(`TXF_OFF_AUX, {6'h3f, i[1:0]});
      chk("pa_supply", 16'(pa_supply_voltage_sel_out), 16'(i));
    end
    // port control, then embedded control from the stream bit
    host.wr(`TXF_OFF_IQIFC0, 8'h14);
    txchk(0, 1'b0, 1'b0);
    @(posedge ref_clk_in);
    tx_prepare_state_in <= 1'b1;
    txchk(0, 1'b0, 1'b1);
    txchk(2, 1'b0, 1'b1);
    txchk(1, 1'b0, 1'b0);
    host.wr(`TXF_OFF_IQIFC0, 8'h15);
    chk("eec", 16'(embedded_tx_ctrl_en_out), 16'h1);
    chk("iq_cfg", 16'(iq_interface_config0_out), 16'h15);
    txchk(0, 1'b0, 1'b0);
    txchk(2, 1'b1, 1'b1);
    txchk(1, 1'b0, 1'b1);
    txchk(2, 1'b0, 1'b0);
    wrap_up();
  end
endmodule : txf_config_regs_tb

bind txf_config_regs txf_regs_properties u_props (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .tx_prepare_state_in(tx_prepare_state_in), .iq_ctrl_bit_in(iq_ctrl_bit_in),
  .iq_valid_in(iq_valid_in), .iq_status_flag_in(iq_status_flag_in),
  .tx_active_out(tx_active_out), .pa_ramp_time_sel_out(pa_ramp_time_sel_out),
  .pa_ramp_cycles_out(pa_ramp_cycles_out), .tx_lpf_cutoff_sel_out(tx_lpf_cutoff_sel_out),
  .tx_rel_cutoff_sel_out(tx_rel_cutoff_sel_out), .direct_mod_enable_out(direct_mod_enable_out),
  .tx_sample_rate_sel_out(tx_sample_rate_sel_out),
  .pa_bias_current_sel_out(pa_bias_current_sel_out), .tx_power_level_out(tx_power_level_out),
  .pa_supply_voltage_sel_out(pa_supply_voltage_sel_out),
  .iq_interface_config0_out(iq_interface_config0_out),
  .embedded_tx_ctrl_en_out(embedded_tx_ctrl_en_out));
